// ==== hdl/pps_defs.svh ====
// timing counts, thresholds and limits of the protection sequencer
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// ------------------------------------------------------------
// thresholds in 0.1 mV units, 14 bits
// ------------------------------------------------------------
`define PPS_STARTUP_CURRENT_THRESHOLD 14'h157c
`define PPS_BURST_EXIT_CURRENT_THRESHOLD 14'h1d4c
`define PPS_NORMAL_CURRENT_THRESHOLD 14'h10b3

// ------------------------------------------------------------
// limits and timing
// ------------------------------------------------------------
`define PPS_OC1_EVENT_MAX 4'h8
`define PPS_CLK_HZ 10000000
`define PPS_RESTART_BREAK_MS 1000
`define PPS_RESTART_BREAK_CYC ((`PPS_CLK_HZ / 1000) * `PPS_RESTART_BREAK_MS)
`define PPS_BROWNOUT_BLANK_MS 120
`define PPS_BROWNOUT_BLANK_CYC ((`PPS_CLK_HZ / 1000) * `PPS_BROWNOUT_BLANK_MS)
`define PPS_PAUSE_NS 10000
`define PPS_PAUSE_CYC ((`PPS_PAUSE_NS + 99) / 100)
`define PPS_INIT_CYC 8'h10
`define PPS_SLOPE_STEP 16'h0010
`define PPS_CNT_W 24

`endif

// ==== hdl/pps_pkg.sv ====
// state types of the protection sequencer
package pps_pkg;

	typedef enum logic [2:0] {
		PPS_SYS_INIT = 3'b000,
		PPS_SYS_RUN = 3'b001,
		PPS_SYS_RESTART = 3'b010
	} pps_sys_t;

	typedef enum logic [2:0] {
		PPS_PFC_OFF = 3'b000,
		PPS_PFC_LOOPCHK = 3'b001,
		PPS_PFC_SOFT = 3'b010,
		PPS_PFC_NORMAL = 3'b011,
		PPS_PFC_PAUSE = 3'b100,
		PPS_PFC_RESTART = 3'b101,
		PPS_PFC_BROWN = 3'b110
	} pps_pfc_t;

	typedef enum logic [1:0] {
		PPS_HB_OFF = 2'b00,
		PPS_HB_BUSCHK = 2'b01,
		PPS_HB_SOFT = 2'b10,
		PPS_HB_NORMAL = 2'b11
	} pps_hb_t;

endpackage

// ==== hdl/pps_timer.sv ====
// load-and-count-down timer with done flag
`timescale 1ns/100ps
module pps_timer (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// control
	input wire logic i_load,
	input wire logic [23:0] i_count,
	// status
	output logic o_done
);
	logic [23:0] cnt_r;
	logic [23:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (i_load) begin
			cnt_nxt = i_count;
		end else if (cnt_r != 24'h000000) begin
			cnt_nxt = cnt_r - 24'h000001;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 24'h000000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign o_done = (cnt_r == 24'h000000) && !i_load;
endmodule // pps_timer

// ==== hdl/pps_freq_limiter.sv ====
// level-one overcurrent frequency push-back and threshold select
`include "pps_defs.svh"
`timescale 1ns/100ps
module pps_freq_limiter (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// context
	input wire logic i_active,
	input wire logic i_startup,
	input wire logic i_burst_exit,
	input wire logic i_cycle_strobe,
	input wire logic [13:0] i_shunt_mv10,
	input wire logic [15:0] i_feedback_freq,
	input wire logic [15:0] i_base_freq,
	// results
	output logic o_event,
	output logic o_limiting,
	output logic [15:0] o_freq
);
	logic [15:0] freq_r;
	logic [15:0] freq_nxt;
	logic lim_r;
	logic lim_nxt;
	logic [13:0] thr;
	logic over;

	always_comb begin
		if (i_startup) begin
			thr = `PPS_STARTUP_CURRENT_THRESHOLD;
		end else if (i_burst_exit) begin
			thr = `PPS_BURST_EXIT_CURRENT_THRESHOLD;
		end else begin
			thr = `PPS_NORMAL_CURRENT_THRESHOLD;
		end
	end

	assign over = i_shunt_mv10 > thr;

	always_comb begin
		freq_nxt = freq_r;
		lim_nxt = lim_r;
		if (!i_active) begin
			lim_nxt = 1'b0;
			freq_nxt = i_base_freq;
		end else if (i_cycle_strobe) begin
			if (over) begin
				// saturate rather than wrap at the top of the range
				if (!lim_r) begin
					freq_nxt = i_base_freq;
				end else if (freq_r < 16'hffff - `PPS_SLOPE_STEP) begin
					freq_nxt = freq_r + `PPS_SLOPE_STEP;
				end else begin
					freq_nxt = 16'hffff;
				end
				lim_nxt = 1'b1;
			end else if (lim_r) begin
				if (i_feedback_freq > freq_r) begin
					lim_nxt = 1'b0;
				end else if (freq_r > `PPS_SLOPE_STEP) begin
					freq_nxt = freq_r - `PPS_SLOPE_STEP;
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			freq_r <= 16'h0000;
			lim_r <= 1'b0;
		end else begin
			freq_r <= freq_nxt;
			lim_r <= lim_nxt;
		end
	end

	assign o_event = i_active && i_cycle_strobe && over;
	assign o_limiting = lim_r;
	assign o_freq = lim_r ? freq_r : i_feedback_freq;
endmodule // pps_freq_limiter

// ==== hdl/pps_sequencer.sv ====
// protection and start-up sequencer for the correction and half-bridge stages
`include "pps_defs.svh"
`timescale 1ns/100ps

// Overview of operation
// - check level-one overcurrent once per half-bridge switching cycle from shunt sense
// - threshold 550 mV startup, 750 mV leaving burst, 427.5 mV normal
// - above threshold, raise half-bridge frequency at a configured slope
// - below threshold again, start lowering the raised frequency
// - hand back to feedback oscillator once its frequency is higher
// - count level-one events, maximum count of eight
// - level-two comparator trip puts whole system into auto-restart
// - latch the level-two comparator state for readback
// - auto-restart stops switching, waits break time, restarts with softstart
// - after supply turn-on, initialise setup values then enable both stages
// - correction stage disabled: no sampling, no pulses, gate held low
// - correction enable: check open loop first, softstart only if none
// - correction softstart limits integrator, goes normal near rated bus
// - overcurrent does not stop correction; overvoltage pauses until bus rated
// - prolonged conduction mode: correction auto-restart, then softstart after break
// - half-bridge disabled: no sampling, both gates low
// - half-bridge waits for start bus level, then falling time-ramp softstart
// - softstart ends when feedback frequency meets ramp frequency
// - undervoltage returns to bus check; open loop or overload in normal mode restart after break
// - block correction gate while on-time below minimum, release above it
// - correction overcurrent past blanking ends pulse; next on from zero-cross or timeout
// - brownout stops correction after blanking, half-bridge keeps switching
module pps_sequencer (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// supply and bus conditions
	input wire logic i_supply_ok,
	input wire logic i_bus_open_loop,
	input wire logic i_bus_near_rated,
	input wire logic i_bus_at_rated,
	input wire logic i_bus_overvoltage_soft,
	input wire logic i_bus_overvoltage_hard,
	input wire logic i_bus_undervoltage,
	input wire logic i_halfbridge_start_bus_level,
	input wire logic i_ac_brownout,
	input wire logic i_ccm_prolonged,
	// correction stage
	input wire logic i_correction_pulse_req,
	input wire logic i_on_time_below_min,
	input wire logic i_correction_overcurrent_blanked,
	input wire logic i_zero_crossing_detect,
	input wire logic i_max_period_expired,
	// half-bridge stage
	input wire logic i_halfbridge_cycle,
	input wire logic [13:0] i_halfbridge_current_sense,
	input wire logic i_overcurrent_level_two,
	input wire logic i_halfbridge_open_loop,
	input wire logic i_halfbridge_overload,
	input wire logic i_burst_exit,
	input wire logic [15:0] i_feedback_oscillator_freq,
	input wire logic [15:0] i_time_ramp_oscillator_freq,
	input wire logic i_level_two_clear,
	// gate drive
	output logic o_correction_gate,
	output logic o_correction_sample_en,
	output logic o_integrator_limit,
	output logic o_halfbridge_gate_en,
	output logic o_halfbridge_sample_en,
	output logic o_ramp_run,
	// frequency and status
	output logic [15:0] o_halfbridge_freq,
	output logic o_freq_limiting,
	output logic o_level_two_latched,
	output logic [3:0] o_level_one_count,
	output logic o_system_restart
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pps_pkg::pps_sys_t sys_r, sys_nxt;
	pps_pkg::pps_pfc_t pfc_r, pfc_nxt;
	pps_pkg::pps_hb_t hb_r, hb_nxt;
	logic [3:0] oc1_cnt_r, oc1_cnt_nxt;
	logic l2_r, l2_nxt;
	logic gate_r, gate_nxt;
	logic armed_r, armed_nxt;
	logic [7:0] init_r, init_nxt;
	logic hb_brk_r, hb_brk_nxt;
	logic oc1_event, limiting, sys_fault, hb_fault, pfc_fault;
	logic sys_tmr_load, pfc_tmr_load, hb_tmr_load, blank_load;
	logic sys_tmr_done, pfc_tmr_done, hb_tmr_done, blank_done;
	logic [23:0] pfc_tmr_count;
	logic [15:0] lim_freq;

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	pps_timer u_sys_tmr (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load(sys_tmr_load),
		.i_count(24'(`PPS_RESTART_BREAK_CYC)), .o_done(sys_tmr_done));
	pps_timer u_pfc_tmr (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load(pfc_tmr_load),
		.i_count(pfc_tmr_count), .o_done(pfc_tmr_done));
	pps_timer u_hb_tmr (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load(hb_tmr_load),
		.i_count(24'(`PPS_RESTART_BREAK_CYC)), .o_done(hb_tmr_done));
	pps_timer u_blank_tmr (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_load(blank_load),
		.i_count(24'(`PPS_BROWNOUT_BLANK_CYC)), .o_done(blank_done));

	pps_freq_limiter u_lim (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_active(hb_r == pps_pkg::PPS_HB_SOFT || hb_r == pps_pkg::PPS_HB_NORMAL),
		.i_startup(hb_r == pps_pkg::PPS_HB_SOFT),
		.i_burst_exit(i_burst_exit),
		.i_cycle_strobe(i_halfbridge_cycle),
		.i_shunt_mv10(i_halfbridge_current_sense),
		.i_feedback_freq(i_feedback_oscillator_freq),
		.i_base_freq(hb_r == pps_pkg::PPS_HB_SOFT ? i_time_ramp_oscillator_freq : i_feedback_oscillator_freq),
		.o_event(oc1_event),
		.o_limiting(limiting),
		.o_freq(lim_freq)
	);

	// ------------------------------------------------------------
	// system level
	// ------------------------------------------------------------
	assign hb_fault = (hb_r == pps_pkg::PPS_HB_SOFT || hb_r == pps_pkg::PPS_HB_NORMAL);
	// level-two trip acts even while the latch is still set from before
	assign sys_fault = (hb_fault && i_overcurrent_level_two)
		|| (oc1_event && oc1_cnt_r == `PPS_OC1_EVENT_MAX - 4'h1);

	always_comb begin
		sys_nxt = sys_r;
		init_nxt = init_r;
		sys_tmr_load = 1'b0;
		oc1_cnt_nxt = oc1_cnt_r;
		l2_nxt = l2_r;
		if (oc1_event) begin
			oc1_cnt_nxt = oc1_cnt_r + 4'h1;
		end
		// set beats clear
		if (i_level_two_clear) begin
			l2_nxt = 1'b0;
		end
		if (i_overcurrent_level_two && hb_fault) begin
			l2_nxt = 1'b1;
		end
		case (sys_r)
			pps_pkg::PPS_SYS_INIT: begin
				if (!i_supply_ok) begin
					init_nxt = 8'h00;
				end else if (init_r == `PPS_INIT_CYC) begin
					sys_nxt = pps_pkg::PPS_SYS_RUN;
				end else begin
					init_nxt = init_r + 8'h01;
				end
				oc1_cnt_nxt = 4'h0;
			end
			pps_pkg::PPS_SYS_RUN: begin
				if (!i_supply_ok) begin
					sys_nxt = pps_pkg::PPS_SYS_INIT;
					init_nxt = 8'h00;
				end else if (sys_fault) begin
					sys_nxt = pps_pkg::PPS_SYS_RESTART;
					sys_tmr_load = 1'b1;
					oc1_cnt_nxt = 4'h0;
				end
			end
			pps_pkg::PPS_SYS_RESTART: begin
				oc1_cnt_nxt = 4'h0;
				if (sys_tmr_done) begin
					sys_nxt = pps_pkg::PPS_SYS_RUN;
				end
			end
			default: begin
				sys_nxt = pps_pkg::PPS_SYS_INIT;
			end
		endcase
	end

	// ------------------------------------------------------------
	// correction stage
	// ------------------------------------------------------------
	assign pfc_fault = (pfc_r == pps_pkg::PPS_PFC_SOFT || pfc_r == pps_pkg::PPS_PFC_NORMAL);

	always_comb begin
		pfc_nxt = pfc_r;
		pfc_tmr_load = 1'b0;
		pfc_tmr_count = 24'(`PPS_RESTART_BREAK_CYC);
		blank_load = 1'b0;
		if (sys_nxt != pps_pkg::PPS_SYS_RUN || sys_r != pps_pkg::PPS_SYS_RUN) begin
			pfc_nxt = pps_pkg::PPS_PFC_OFF;
		end else begin
			case (pfc_r)
				pps_pkg::PPS_PFC_OFF: pfc_nxt = pps_pkg::PPS_PFC_LOOPCHK;
				pps_pkg::PPS_PFC_LOOPCHK: begin
					if (!i_bus_open_loop) begin
						pfc_nxt = pps_pkg::PPS_PFC_SOFT;
					end
				end
				pps_pkg::PPS_PFC_SOFT: begin
					if (i_bus_near_rated) begin
						pfc_nxt = pps_pkg::PPS_PFC_NORMAL;
					end
				end
				pps_pkg::PPS_PFC_NORMAL: ;
				pps_pkg::PPS_PFC_PAUSE: begin
					if (i_bus_at_rated && pfc_tmr_done) begin
						pfc_nxt = pps_pkg::PPS_PFC_NORMAL;
					end
				end
				pps_pkg::PPS_PFC_RESTART: begin
					if (pfc_tmr_done) begin
						pfc_nxt = pps_pkg::PPS_PFC_SOFT;
					end
				end
				pps_pkg::PPS_PFC_BROWN: begin
					if (!i_ac_brownout) begin
						pfc_nxt = pps_pkg::PPS_PFC_LOOPCHK;
					end
				end
				default: pfc_nxt = pps_pkg::PPS_PFC_OFF;
			endcase
			// overcurrent only trims the pulse; it never enters this flow
			if (pfc_fault) begin
				if (!i_ac_brownout) begin
					blank_load = 1'b1;
				end else if (blank_done) begin
					pfc_nxt = pps_pkg::PPS_PFC_BROWN;
				end
				if (i_ccm_prolonged) begin
					pfc_nxt = pps_pkg::PPS_PFC_RESTART;
					pfc_tmr_load = 1'b1;
				end else if (i_bus_overvoltage_soft || i_bus_overvoltage_hard) begin
					pfc_nxt = pps_pkg::PPS_PFC_PAUSE;
					pfc_tmr_load = 1'b1;
					pfc_tmr_count = 24'(`PPS_PAUSE_CYC);
				end
			end else begin
				blank_load = 1'b1;
			end
		end
	end

	// gate pulse: ended by blanked overcurrent, re-armed by zero-cross or timeout
	always_comb begin
		gate_nxt = 1'b0;
		armed_nxt = armed_r;
		if (!pfc_fault) begin
			armed_nxt = 1'b1;
		end else begin
			if (i_correction_overcurrent_blanked && gate_r) begin
				armed_nxt = 1'b0;
			end else if (i_zero_crossing_detect || i_max_period_expired) begin
				armed_nxt = 1'b1;
			end
			gate_nxt = i_correction_pulse_req && armed_nxt && !i_on_time_below_min;
		end
	end

	// ------------------------------------------------------------
	// half-bridge stage
	// ------------------------------------------------------------
	always_comb begin
		hb_nxt = hb_r;
		hb_tmr_load = 1'b0;
		hb_brk_nxt = hb_brk_r;
		if (sys_nxt != pps_pkg::PPS_SYS_RUN || sys_r != pps_pkg::PPS_SYS_RUN) begin
			hb_nxt = pps_pkg::PPS_HB_OFF;
			hb_brk_nxt = 1'b0;
		end else begin
			case (hb_r)
				pps_pkg::PPS_HB_OFF: hb_nxt = pps_pkg::PPS_HB_BUSCHK;
				pps_pkg::PPS_HB_BUSCHK: begin
					if (i_halfbridge_start_bus_level && (!hb_brk_r || hb_tmr_done)) begin
						hb_nxt = pps_pkg::PPS_HB_SOFT;
						hb_brk_nxt = 1'b0;
					end
				end
				pps_pkg::PPS_HB_SOFT: begin
					if (i_feedback_oscillator_freq >= i_time_ramp_oscillator_freq) begin
						hb_nxt = pps_pkg::PPS_HB_NORMAL;
					end
				end
				pps_pkg::PPS_HB_NORMAL: ;
				default: hb_nxt = pps_pkg::PPS_HB_OFF;
			endcase
			if (hb_fault) begin
				if (i_bus_undervoltage) begin
					hb_nxt = pps_pkg::PPS_HB_BUSCHK;
				end else if (hb_r == pps_pkg::PPS_HB_NORMAL && (i_halfbridge_open_loop || i_halfbridge_overload)) begin
					hb_nxt = pps_pkg::PPS_HB_BUSCHK;
					hb_brk_nxt = 1'b1;
					hb_tmr_load = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sys_r <= pps_pkg::PPS_SYS_INIT;
			pfc_r <= pps_pkg::PPS_PFC_OFF;
			hb_r <= pps_pkg::PPS_HB_OFF;
			oc1_cnt_r <= 4'h0;
			l2_r <= 1'b0;
			gate_r <= 1'b0;
			armed_r <= 1'b1;
			init_r <= 8'h00;
			hb_brk_r <= 1'b0;
		end else begin
			sys_r <= sys_nxt;
			pfc_r <= pfc_nxt;
			hb_r <= hb_nxt;
			oc1_cnt_r <= oc1_cnt_nxt;
			l2_r <= l2_nxt;
			gate_r <= gate_nxt;
			armed_r <= armed_nxt;
			init_r <= init_nxt;
			hb_brk_r <= hb_brk_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_correction_gate = gate_r;
	assign o_correction_sample_en = (pfc_r != pps_pkg::PPS_PFC_OFF) && (pfc_r != pps_pkg::PPS_PFC_BROWN);
	assign o_integrator_limit = (pfc_r == pps_pkg::PPS_PFC_SOFT);
	assign o_halfbridge_gate_en = hb_fault;
	assign o_halfbridge_sample_en = (hb_r != pps_pkg::PPS_HB_OFF);
	assign o_ramp_run = (hb_r == pps_pkg::PPS_HB_SOFT);
	assign o_halfbridge_freq = hb_fault ? lim_freq : 16'h0000;
	assign o_freq_limiting = limiting;
	assign o_level_two_latched = l2_r;
	assign o_level_one_count = oc1_cnt_r;
	assign o_system_restart = (sys_r == pps_pkg::PPS_SYS_RESTART);
endmodule // pps_sequencer

// ==== testbench/pps_sequencer_asserts.sv ====
// concurrent checks on the protection sequencer ports
`timescale 1ns/100ps
module pps_sequencer_chk (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// watched inputs
	input wire logic i_halfbridge_cycle,
	input wire logic [13:0] i_halfbridge_current_sense,
	input wire logic i_overcurrent_level_two,
	input wire logic i_level_two_clear,
	input wire logic i_on_time_below_min,
	// watched outputs
	input wire logic o_correction_gate,
	input wire logic o_correction_sample_en,
	input wire logic o_halfbridge_gate_en,
	input wire logic o_halfbridge_sample_en,
	input wire logic o_freq_limiting,
	input wire logic o_level_two_latched,
	input wire logic [3:0] o_level_one_count,
	input wire logic o_system_restart
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// ------------------------------------------------------------
	// level-one handling
	// ------------------------------------------------------------
	// the lowest of the three thresholds bounds every trigger
	property p_limit_cause;
		$rose(o_freq_limiting) |-> $past(i_halfbridge_cycle) && ($past(i_halfbridge_current_sense) > 14'h10b3);
	endproperty
	a_limit_cause: assert property (p_limit_cause) else $error("limiting without a cycle over threshold");
	property p_count_step;
		(o_level_one_count > $past(o_level_one_count)) |->
			$past(i_halfbridge_cycle) && (o_level_one_count == $past(o_level_one_count) + 4'h1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("event count stepped wrongly");
	property p_count_max;
		o_level_one_count <= 4'h8;
	endproperty
	a_count_max: assert property (p_count_max) else $error("event count above limit");

	// ------------------------------------------------------------
	// level-two and restart
	// ------------------------------------------------------------
	property p_level_two;
		i_overcurrent_level_two && o_halfbridge_gate_en && !o_system_restart |=> o_level_two_latched && o_system_restart;
	endproperty
	a_level_two: assert property (p_level_two) else $error("level-two trip not taken");
	property p_latch_hold;
		o_level_two_latched && !i_level_two_clear |=> o_level_two_latched;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("level-two latch lost");
	property p_restart_quiet;
		o_system_restart && $past(o_system_restart) |-> !o_correction_gate && !o_halfbridge_gate_en;
	endproperty
	a_restart_quiet: assert property (p_restart_quiet) else $error("switching during restart");

	// ------------------------------------------------------------
	// gate blocking
	// ------------------------------------------------------------
	property p_corr_off;
		!o_correction_sample_en && !$past(o_correction_sample_en) |-> !o_correction_gate;
	endproperty
	a_corr_off: assert property (p_corr_off) else $error("correction gate while disabled");
	property p_hb_off;
		!o_halfbridge_sample_en |-> !o_halfbridge_gate_en;
	endproperty
	a_hb_off: assert property (p_hb_off) else $error("half-bridge gate while disabled");
	property p_min_on;
		i_on_time_below_min |=> !o_correction_gate;
	endproperty
	a_min_on: assert property (p_min_on) else $error("gate below minimum on-time");
endmodule // pps_sequencer_chk

bind pps_sequencer pps_sequencer_chk u_chk (.i_clock, .i_rst_n, .i_halfbridge_cycle, .i_halfbridge_current_sense,
	.i_overcurrent_level_two, .i_level_two_clear, .i_on_time_below_min, .o_correction_gate, .o_correction_sample_en,
	.o_halfbridge_gate_en, .o_halfbridge_sample_en, .o_freq_limiting, .o_level_two_latched, .o_level_one_count,
	.o_system_restart);

// ==== testbench/pps_power_stage.sv ====
// power stage model: switching strobe, shunt sense and level-two comparator
`timescale 1ns/100ps
module pps_power_stage #(
	parameter int CYCLE_LEN = 8,
	parameter logic [13:0] LEVEL_TWO_MV10 = 14'h2710
) (
	// clock
	input wire logic i_clock,
	// stage drive and wanted shunt level
	input wire logic i_halfbridge_gate_en,
	input wire logic [13:0] i_shunt_mv10,
	// sense back to the controller
	output logic o_halfbridge_cycle,
	output logic [13:0] o_current_sense,
	output logic o_overcurrent_level_two
);
	int cnt_r = 0;
	// no switching means no tank current, so strobe and sense drop with the gates
	always_ff @(posedge i_clock) begin
		cnt_r <= (i_halfbridge_gate_en && cnt_r < CYCLE_LEN - 1) ? cnt_r + 1 : 0;
	end
	assign o_halfbridge_cycle = i_halfbridge_gate_en && (cnt_r == CYCLE_LEN - 1);
	assign o_current_sense = i_halfbridge_gate_en ? i_shunt_mv10 : 14'h0000;
	assign o_overcurrent_level_two = o_current_sense > LEVEL_TWO_MV10;
endmodule // pps_power_stage

// ==== testbench/tb.sv ====
// self-checking bench of the protection sequencer
`timescale 1ns/100ps
module tb;
	logic i_clock, i_rst_n, i_supply_ok, i_bus_open_loop, i_bus_near_rated, i_bus_at_rated, i_bus_overvoltage_soft;
	logic i_bus_overvoltage_hard, i_bus_undervoltage, i_halfbridge_start_bus_level, i_ac_brownout, i_ccm_prolonged;
	logic i_correction_pulse_req, i_on_time_below_min, i_correction_overcurrent_blanked, i_zero_crossing_detect;
	logic i_max_period_expired, i_halfbridge_open_loop, i_halfbridge_overload, i_burst_exit, i_level_two_clear;
	logic [15:0] i_feedback_oscillator_freq, i_time_ramp_oscillator_freq, o_halfbridge_freq, f0;
	logic [13:0] shunt, i_halfbridge_current_sense;
	logic i_halfbridge_cycle, i_overcurrent_level_two, o_correction_gate, o_correction_sample_en, o_integrator_limit;
	logic o_halfbridge_gate_en, o_halfbridge_sample_en, o_ramp_run, o_freq_limiting, o_level_two_latched;
	logic o_system_restart;
	logic [3:0] o_level_one_count;
	logic [9:0] mon;
	int error_cnt = 0;
	int comparisons = 0;

	pps_sequencer uut (.i_clock, .i_rst_n, .i_supply_ok, .i_bus_open_loop, .i_bus_near_rated, .i_bus_at_rated,
		.i_bus_overvoltage_soft, .i_bus_overvoltage_hard, .i_bus_undervoltage, .i_halfbridge_start_bus_level,
		.i_ac_brownout, .i_ccm_prolonged, .i_correction_pulse_req, .i_on_time_below_min,
		.i_correction_overcurrent_blanked, .i_zero_crossing_detect, .i_max_period_expired, .i_halfbridge_cycle,
		.i_halfbridge_current_sense, .i_overcurrent_level_two, .i_halfbridge_open_loop, .i_halfbridge_overload,
		.i_burst_exit, .i_feedback_oscillator_freq, .i_time_ramp_oscillator_freq, .i_level_two_clear,
		.o_correction_gate, .o_correction_sample_en, .o_integrator_limit, .o_halfbridge_gate_en,
		.o_halfbridge_sample_en, .o_ramp_run, .o_halfbridge_freq, .o_freq_limiting, .o_level_two_latched,
		.o_level_one_count, .o_system_restart);
	pps_power_stage u_stage (.i_clock, .i_halfbridge_gate_en(o_halfbridge_gate_en), .i_shunt_mv10(shunt),
		.o_halfbridge_cycle(i_halfbridge_cycle), .o_current_sense(i_halfbridge_current_sense),
		.o_overcurrent_level_two(i_overcurrent_level_two));
	assign mon = {i_halfbridge_cycle, o_system_restart, o_level_two_latched, o_freq_limiting, o_ramp_run,
		o_halfbridge_sample_en, o_halfbridge_gate_en, o_integrator_limit, o_correction_sample_en, o_correction_gate};

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick;
		@(posedge i_clock);
		#10;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// bounded wait on one monitored flag; a hang ends the run
	task automatic wait_bit(input int idx, input logic val, input int bound);
		for (int n = 0; n < bound && mon[idx] !== val; n++) tick;
		comparisons++;
		if (mon[idx] !== val) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: flag %0d timed out", $time, idx);
			summarize;
		end
	endtask
	// exactly one switching cycle sees the given shunt level
	task automatic one_event(input logic [13:0] lvl);
		shunt = lvl;
		wait_bit(9, 1'b1, 40);
		tick;
		shunt = 14'h0000;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_startup;
		repeat (10) tick;
		check(16'(o_correction_sample_en), 16'h0000);
		repeat (30) tick;
		check(16'(o_integrator_limit), 16'h0000);
		check(16'(o_halfbridge_gate_en), 16'h0000);
		i_bus_open_loop = 1'b0;
		wait_bit(2, 1'b1, 50);
		i_halfbridge_start_bus_level = 1'b1;
		wait_bit(3, 1'b1, 50);
		check(16'(o_ramp_run), 16'h0001);
		one_event(14'h157c);
		check(16'(o_level_one_count), 16'h0000);
		one_event(14'h157d);
		check(16'(o_level_one_count), 16'h0001);
		i_feedback_oscillator_freq = 16'h8000;
		wait_bit(5, 1'b0, 50);
		i_feedback_oscillator_freq = 16'hffff;
		wait_bit(6, 1'b0, 50);
		check(o_halfbridge_freq, 16'hffff);
	endtask
	task automatic t_level_one;
		i_feedback_oscillator_freq = 16'h1000;
		one_event(14'h10b3);
		check(16'(o_level_one_count), 16'h0001);
		one_event(14'h10b4);
		check(16'(o_freq_limiting), 16'h0001);
		f0 = o_halfbridge_freq;
		one_event(14'h10b4);
		check(o_halfbridge_freq, f0 + 16'h0010);
		check(16'(o_level_one_count), 16'h0003);
		f0 = o_halfbridge_freq;
		repeat (20) tick;
		check(16'(o_halfbridge_freq < f0), 16'h0001);
		i_burst_exit = 1'b1;
		one_event(14'h1d4c);
		check(16'(o_level_one_count), 16'h0003);
		one_event(14'h1d4d);
		check(16'(o_level_one_count), 16'h0004);
		i_burst_exit = 1'b0;
	endtask
	task automatic t_correction;
		i_correction_pulse_req = 1'b1;
		i_on_time_below_min = 1'b1;
		tick;
		tick;
		check(16'(o_correction_gate), 16'h0000);
		i_on_time_below_min = 1'b0;
		wait_bit(0, 1'b1, 20);
		i_correction_overcurrent_blanked = 1'b1;
		tick;
		tick;
		check(16'(o_correction_gate), 16'h0000);
		check(16'(o_correction_sample_en), 16'h0001);
		i_correction_overcurrent_blanked = 1'b0;
		repeat (5) tick;
		check(16'(o_correction_gate), 16'h0000);
		i_zero_crossing_detect = 1'b1;
		tick;
		i_zero_crossing_detect = 1'b0;
		wait_bit(0, 1'b1, 20);
		i_bus_near_rated = 1'b1;
		wait_bit(2, 1'b0, 5);
		i_bus_overvoltage_soft = 1'b1;
		wait_bit(0, 1'b0, 20);
		i_bus_overvoltage_soft = 1'b0;
		repeat (150) tick;
		check(16'(o_correction_gate), 16'h0000);
		i_bus_at_rated = 1'b1;
		i_zero_crossing_detect = 1'b1;
		tick;
		i_zero_crossing_detect = 1'b0;
		wait_bit(0, 1'b1, 30);
	endtask
	task automatic t_brown_ccm;
		i_ac_brownout = 1'b1;
		repeat (300) tick;
		check(16'(o_correction_sample_en), 16'h0001);
		check(16'(o_halfbridge_gate_en), 16'h0001);
		i_ac_brownout = 1'b0;
		i_ccm_prolonged = 1'b1;
		wait_bit(0, 1'b0, 30);
		check(16'(o_halfbridge_gate_en), 16'h0001);
		i_ccm_prolonged = 1'b0;
	endtask
	task automatic t_level_one_max;
		repeat (3) one_event(14'h2000);
		check(16'(o_level_one_count), 16'h0007);
		one_event(14'h2000);
		wait_bit(8, 1'b1, 5);
		tick;
		check(16'(o_level_one_count), 16'h0000);
		check(16'({o_halfbridge_gate_en, o_correction_gate}), 16'h0000);
	endtask
	task automatic t_level_two;
		i_rst_n = 1'b0;
		tick;
		tick;
		i_rst_n = 1'b1;
		wait_bit(3, 1'b1, 100);
		shunt = 14'h3000;
		wait_bit(7, 1'b1, 5);
		check(16'(o_system_restart), 16'h0001);
		shunt = 14'h0000;
		repeat (3) tick;
		check(16'({o_level_two_latched, o_halfbridge_gate_en}), 16'h0002);
		i_level_two_clear = 1'b1;
		tick;
		i_level_two_clear = 1'b0;
		tick;
		check(16'(o_level_two_latched), 16'h0000);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{i_rst_n, i_bus_near_rated, i_bus_at_rated, i_bus_overvoltage_soft, i_bus_overvoltage_hard} = '0;
		{i_bus_undervoltage, i_halfbridge_start_bus_level, i_ac_brownout, i_ccm_prolonged} = '0;
		{i_correction_pulse_req, i_on_time_below_min, i_correction_overcurrent_blanked, i_zero_crossing_detect} = '0;
		{i_max_period_expired, i_halfbridge_open_loop, i_halfbridge_overload, i_burst_exit, i_level_two_clear} = '0;
		i_supply_ok = 1'b1;
		i_bus_open_loop = 1'b1;
		i_feedback_oscillator_freq = 16'h1000;
		i_time_ramp_oscillator_freq = 16'h8000;
		shunt = 14'h0000;
		repeat (4) @(posedge i_clock);
		#10;
		check({6'h00, mon[8:0], o_level_one_count == 4'h0}, 16'h0001);
		check(o_halfbridge_freq, 16'h0000);
		i_rst_n = 1'b1;
		t_startup;
		t_level_one;
		t_correction;
		t_brown_ccm;
		t_level_one_max;
		t_level_two;
		summarize;
	end
endmodule // tb
